/* dv/sirq_host_model.sv */
// Host controller model for the serial interrupt wire.
// Assumes the bench resolves a pulled-up wire from all enables.
`timescale 1ns/1ps
module sirq_host_model #(
  parameter int SLACK = 0
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wire_i,
  input wire logic go_i,
  input wire logic [3:0] hold_i,
  input wire logic [3:0] stop_i,
  output logic host_o,
  output logic host_oe_o,
  output logic busy_o
);
  task automatic drive(input logic v, input int n);
    host_o <= v;
    host_oe_o <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
  endtask : drive

  initial begin
    host_o = 1'b1;
    host_oe_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge sys_clk_i);
      if (reset_n_i && (go_i || !wire_i)) begin
        busy_o <= 1'b1;
        drive(1'b0, go_i ? int'(hold_i) + 1 : int'(hold_i));
        drive(1'b1, 1);
        host_oe_o <= 1'b0;
        repeat (52 + SLACK) @(posedge sys_clk_i);
        drive(1'b0, int'(stop_i));
        drive(1'b1, 1);
        host_oe_o <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        busy_o <= 1'b0;
      end
    end
  end
endmodule : sirq_host_model

/* dv/tb_serial_irq_slave.sv */
// Bench for the serial interrupt slave against the host controller model.
// Assumes a pulled-up wire; bench inputs change on falling edges.
`timescale 1ns/1ps
module tb_serial_irq_slave;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b1;
  logic go = 1'b0;
  logic [3:0] hold = 4'h3;
  logic [3:0] stop = 4'h3;
  logic [15:0] irq_n = 16'hffff;
  logic mgmt = 1'b1;
  logic smi_en = 1'b0;
  logic d1 = 1'b0;
  logic d2 = 1'b0;
  logic wire_o, wire_oe_o, host_o, host_oe, busy, quiet, active, line;
  int cyc, n_errors, cmp_count;
  int lows[$];
  int rise_cyc;
  logic line_q = 1'b1;
  assign line = !((wire_oe_o && !wire_o) || (host_oe && !host_o));

  sirq_slave i_sirq_slave (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wire_i(line),
    .wire_o(wire_o), .wire_oe_o(wire_oe_o), .irq_n_i(irq_n), .mgmt_interrupt_out_i(mgmt),
    .smi_frame_en_i(smi_en), .quiet_mode_o(quiet), .cycle_active_o(active));
  sirq_host_model i_sirq_host_model (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .wire_i(line), .go_i(go), .hold_i(hold), .stop_i(stop), .host_o(host_o),
    .host_oe_o(host_oe), .busy_o(busy));

  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // Each low sample during a cycle must be followed by a high recovery, then release
  always @(negedge sys_clk_i) begin
    cyc <= cyc + 1;
    line_q <= line;
    if (busy && line && !line_q && lows.size() == 0) rise_cyc <= cyc;
    if (d1) check({wire_oe_o, wire_o}, 2'h3);
    if (d2) check(wire_oe_o, 1'b0);
    d1 <= busy && wire_oe_o && !wire_o;
    d2 <= d1;
    if (busy && wire_oe_o && !wire_o) lows.push_back(cyc);
  end

  task automatic start_host(input logic [3:0] h, input logic [3:0] s);
    @(negedge sys_clk_i);
    hold = h;
    stop = s;
    go = 1'b1;
    lows.delete();
    @(negedge sys_clk_i);
    go = 1'b0;
  endtask : start_host

  task automatic finish(input int exp[$], input logic qm);
    int i;
    logic qm0;
    qm0 = quiet;
    i = 0;
    while (busy !== 1'b0 && i < 400) begin
      @(negedge sys_clk_i);
      i++;
      if (i == 30) check(active, 1'b1);
      if (i == 30) check(quiet, qm0);
    end
    if (i == 400) begin
      n_errors++;
      tally_and_finish();
    end
    repeat (6) @(negedge sys_clk_i);
    check(active, 1'b0);
    check(quiet, qm);
    check(lows.size(), exp.size());
    if (lows.size() == exp.size()) begin
      if (lows.size() > 0) check(lows[0] - rise_cyc, 3 * exp[0] + 2);
      foreach (lows[k]) check(lows[k] - lows[0], 3 * (exp[k] - exp[0]));
    end
  endtask : finish

  task automatic test_reset();
    check(wire_oe_o, 1'b0);
    check(quiet, 1'b0);
    repeat (10) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    repeat (8) @(negedge sys_clk_i);
    irq_n[3] = 1'b0;
    repeat (40) @(negedge sys_clk_i);
    check(busy, 1'b0);
    irq_n[3] = 1'b1;
    $display("test reset finished");
  endtask : test_reset

  task automatic test_frames();
    irq_n = 16'hffde;
    for (int h = 3; h <= 7; h += 4) begin
      start_host(h[3:0], 4'h3);
      finish('{0, 5}, 1'b0);
    end
    $display("test frames finished");
  endtask : test_frames

  task automatic test_smi();
    for (int k = 0; k < 3; k++) begin
      @(negedge sys_clk_i);
      irq_n = {15'h7fff, 1'b0};
      mgmt = (k == 2);
      smi_en = (k != 1);
      irq_n[2] = (k != 2);
      repeat (8) @(negedge sys_clk_i);
      start_host(4'h3, 4'h3);
      if (k == 0) finish('{0, 2}, 1'b0);
      else finish('{0}, 1'b0);
    end
    mgmt = 1'b1;
    smi_en = 1'b0;
    irq_n[2] = 1'b1;
    $display("test smi finished");
  endtask : test_smi

  task automatic test_quiet();
    int i;
    start_host(4'h3, 4'h2);
    finish('{0}, 1'b1);
    stop = 4'h3;
    lows.delete();
    irq_n[4] = 1'b0;
    i = 0;
    while (!(wire_oe_o === 1'b1 && wire_o === 1'b0) && i < 30) begin
      @(negedge sys_clk_i);
      i++;
    end
    check(i < 30, 1'b1);
    if (i == 30) tally_and_finish();
    @(negedge sys_clk_i);
    check(wire_oe_o, 1'b0);
    finish('{0, 4}, 1'b0);
    irq_n[4] = 1'b1;
    repeat (40) @(negedge sys_clk_i);
    check(busy, 1'b0);
    $display("test quiet finished");
  endtask : test_quiet

  initial begin
    #1 reset_n_i = 1'b0;
    @(negedge sys_clk_i);
    test_reset();
    test_frames();
    test_smi();
    test_quiet();
    tally_and_finish();
  end
endmodule : tb_serial_irq_slave

/* hw/sirq_consts.svh */
// Timing and frame constants for the serial interrupt slave.
// Assumes inclusion by bare name from hw/ files only.
`ifndef SIRQ_CONSTS_SVH
`define SIRQ_CONSTS_SVH
`define SIRQ_NUM_FRAMES 8'h11
`define SIRQ_SLOTS 8'h10
`define SIRQ_FRAME_CLKS 2'h3
`define SIRQ_PH_SAMPLE 2'h0
`define SIRQ_PH_RECOVER 2'h1
`define SIRQ_PH_TURN 2'h2
`define SIRQ_STOP_QUIET 4'h2
`define SIRQ_STOP_CONT 4'h3
`define SIRQ_STOP_MAX 4'h3
`define SIRQ_SMI_SLOT 4'h2
`define SIRQ_IDLE_WAIT 2'h2
`define SIRQ_CNT_W 4
`endif

/* hw/sirq_pkg.sv */
// Types for the serial interrupt slave.
// Assumes sirq_consts.svh is available for the modules that use it.
package sirq_pkg;
  typedef enum logic [2:0] {
    SIRQ_IDLE = 3'h0,
    SIRQ_START = 3'h1,
    SIRQ_FRAMES = 3'h2,
    SIRQ_STOP = 3'h3,
    SIRQ_POST = 3'h4
  } sirq_state_t;
  typedef struct packed {
    logic o;
    logic oe;
  } sirq_drive_t;
endpackage : sirq_pkg

/* hw/sirq_slave.sv */
// Serial interrupt wire slave agent: start frames, data frames, stop decode.
// Assumes sys_clk_i is the bus clock and reset_n_i the bus reset; the wire
// is resolved outside from wire_o/wire_oe_o.
//
// Contract
// - Quiet mode, idle wire: device may start a frame with one low clock.
// - After that low clock release the wire; never drive it high.
// - No start frame while a cycle runs; idle only from stop to start.
// - Quiet mode: input change starts a frame unless current cycle delivers it.
// - Continuous mode: only host starts; device stays passive.
// - Mode changes only during a stop frame.
// - After reset assume Continuous mode.
// - Stop low width two selects Quiet, three selects Continuous.
// - Count frames from the rising edge ending the start pulse.
// - Each frame is sample, recovery, turn-around: three clocks.
// - Sample phase: pull low only if captured input is low.
// - Turn-around phase: release the wire.
// - Frame N samples 3N-1 clocks after the start pulse rising edge.
// - Report owned inputs whoever began the start frame.
// - Idle clocks may follow a stop frame before the next start.
// - After two-clock stop anyone starts from second clock past rising edge.
// - Wire held released while bus reset is asserted.
// - Drive and sample on the rising bus clock edge.
// - Management interrupt goes in third frame only when enabled.
`timescale 1ns/1ps
`include "sirq_consts.svh"
module sirq_slave #(
  parameter int NSLOT = 16
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wire_i,
  output logic wire_o,
  output logic wire_oe_o,
  input wire logic [NSLOT-1:0] irq_n_i,
  input wire logic mgmt_interrupt_out_i,
  input wire logic smi_frame_en_i,
  output logic quiet_mode_o,
  output logic cycle_active_o
);
  sirq_pkg::sirq_state_t state;
  sirq_pkg::sirq_state_t next_state;
  sirq_pkg::sirq_drive_t drv;
  logic [NSLOT-1:0] irq_sync;
  logic wire_s;
  logic wire_prev;
  logic quiet;
  logic [7:0] frame;
  logic [1:0] phase;
  logic [3:0] low_cnt;
  logic [1:0] idle_cnt;
  logic [NSLOT-1:0] cap;
  logic [NSLOT-1:0] sent;
  logic pend;
  logic low_sampled;
  logic started;

  // Interrupt request inputs irq_n_i pass the three-stage filter
  sirq_sync #(.W(NSLOT), .INIT({NSLOT{1'b1}})) u_irq_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(irq_n_i),
    .level_o(irq_sync)
  );
  // The wire is driven on this same clock edge, so frame timing uses it unfiltered
  assign wire_s = wire_i;

  // Slot 2 carries the management interrupt when enabled
  wire [NSLOT-1:0] src;
  genvar g;
  generate
    for (g = 0; g < NSLOT; g++) begin : g_src
      if (g == `SIRQ_SMI_SLOT) begin : g_smi
        assign src[g] = smi_frame_en_i ? mgmt_interrupt_out_i : irq_sync[g];
      end else begin : g_irq
        assign src[g] = irq_sync[g];
      end
    end
  endgenerate

  wire rise = wire_s && !wire_prev;
  wire fall = !wire_s && wire_prev;
  wire [7:0] slot_idx = frame - 8'h01;
  wire own_slot = (frame >= 8'h01) && (frame <= `SIRQ_SLOTS);
  wire [3:0] slot = slot_idx[3:0];
  wire changed = |(src ^ sent);
  // Change still deliverable if its slot is not yet sampled this cycle
  wire late = |((src ^ sent) & ~((NSLOT)'((17'h1 << frame) - 17'h1) >> 1));
  wire may_start = quiet && (state == sirq_pkg::SIRQ_IDLE) && (idle_cnt == 2'h0)
    && pend && wire_s;
  wire [3:0] next_slot = slot + 4'h1;
  // One-clock lows of frames past the last one are not stop pulses
  wire stop_width_ok = (low_cnt >= `SIRQ_STOP_QUIET) && (low_cnt <= `SIRQ_STOP_MAX);
  wire stop_seen = (state == sirq_pkg::SIRQ_STOP) && rise && stop_width_ok;
  // The last frame belongs to another agent; the stop frame follows its turn-around
  wire last_frame_end = (frame == `SIRQ_NUM_FRAMES) && (phase == `SIRQ_PH_TURN);

  always_comb begin
    next_state = state;
    case (state)
      sirq_pkg::SIRQ_IDLE: begin
        if (fall || started) begin
          next_state = sirq_pkg::SIRQ_START;
        end
      end
      sirq_pkg::SIRQ_START: begin
        if (rise) begin
          next_state = sirq_pkg::SIRQ_FRAMES;
        end
      end
      sirq_pkg::SIRQ_FRAMES: begin
        if (last_frame_end) begin
          next_state = sirq_pkg::SIRQ_STOP;
        end
      end
      sirq_pkg::SIRQ_STOP: begin
        if (stop_seen) begin
          next_state = sirq_pkg::SIRQ_IDLE;
        end else if (low_cnt > `SIRQ_STOP_MAX) begin
          next_state = sirq_pkg::SIRQ_IDLE;
        end
      end
      default: next_state = sirq_pkg::SIRQ_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= sirq_pkg::SIRQ_IDLE;
      wire_prev <= 1'b1;
      started <= 1'b0;
    end else begin
      state <= next_state;
      wire_prev <= wire_s;
      started <= may_start;
    end
  end

  // Frame and phase counters, starting at the start pulse rising edge
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame <= 8'h00;
      phase <= `SIRQ_PH_RECOVER;
    end else if (state == sirq_pkg::SIRQ_START && rise) begin
      frame <= 8'h00;
      phase <= `SIRQ_PH_TURN;
    end else if (state == sirq_pkg::SIRQ_FRAMES) begin
      if (phase == `SIRQ_PH_TURN) begin
        phase <= `SIRQ_PH_SAMPLE;
        frame <= frame + 8'h01;
      end else begin
        phase <= phase + 2'h1;
      end
    end
  end

  // Stop pulse width decides the next cycle mode
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      quiet <= 1'b0;
      low_cnt <= 4'h0;
      idle_cnt <= 2'h0;
    end else begin
      if (state == sirq_pkg::SIRQ_STOP && !wire_s && low_cnt != 4'hf) begin
        low_cnt <= low_cnt + 4'h1;
      end else if (state != sirq_pkg::SIRQ_STOP || wire_s) begin
        low_cnt <= 4'h0;
      end
      if (stop_seen) begin
        quiet <= (low_cnt == `SIRQ_STOP_QUIET);
        idle_cnt <= `SIRQ_IDLE_WAIT - 2'h1;
      end else if (idle_cnt != 2'h0) begin
        idle_cnt <= idle_cnt - 2'h1;
      end
    end
  end

  // Capture in the turn-around before each sample phase and track what was last reported
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cap <= {NSLOT{1'b1}};
      sent <= {NSLOT{1'b1}};
      pend <= 1'b0;
      low_sampled <= 1'b0;
    end else begin
      if (state == sirq_pkg::SIRQ_FRAMES && own_slot && phase == `SIRQ_PH_TURN) begin
        cap[next_slot] <= src[next_slot];
      end
      if (state == sirq_pkg::SIRQ_FRAMES && own_slot && phase == `SIRQ_PH_SAMPLE) begin
        sent[slot] <= cap[slot];
      end
      if (state == sirq_pkg::SIRQ_START && rise) begin
        cap[0] <= src[0];
      end
      pend <= (state == sirq_pkg::SIRQ_FRAMES) ? late : changed;
      low_sampled <= (state == sirq_pkg::SIRQ_FRAMES) && own_slot
        && (phase == `SIRQ_PH_SAMPLE) && !cap[slot];
    end
  end

  // Pin drive: one-cycle start low, data low in sample, high in recovery
  always_comb begin
    drv.o = 1'b0;
    drv.oe = 1'b0;
    if (started) begin
      drv.oe = 1'b1;
    end else if (state == sirq_pkg::SIRQ_FRAMES && own_slot) begin
      if (phase == `SIRQ_PH_SAMPLE && !cap[slot]) begin
        drv.oe = 1'b1;
      end else if (phase == `SIRQ_PH_RECOVER && low_sampled) begin
        drv.o = 1'b1;
        drv.oe = 1'b1;
      end
    end
  end

  assign wire_o = drv.o;
  assign wire_oe_o = drv.oe;
  assign quiet_mode_o = quiet;
  assign cycle_active_o = (state != sirq_pkg::SIRQ_IDLE);

  property p_start_one;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (started && !wire_o) |=> !(wire_oe_o && !wire_o && started);
  endproperty
  a_start_one: assert property (p_start_one) else $error("start low longer than one clock");

  property p_cont_passive;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (!quiet_mode_o && !cycle_active_o) |-> !wire_oe_o;
  endproperty
  a_cont_passive: assert property (p_cont_passive) else $error("start in continuous mode");

  property p_no_start_active;
    @(posedge sys_clk_i) disable iff (!reset_n_i) started |-> !cycle_active_o;
  endproperty
  a_no_start_active: assert property (p_no_start_active) else $error("start in active cycle");

  property p_recover_high;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (state == sirq_pkg::SIRQ_FRAMES && own_slot && phase == `SIRQ_PH_SAMPLE && wire_oe_o)
      |=> (wire_oe_o && wire_o) ##1 !wire_oe_o;
  endproperty
  a_recover_high: assert property (p_recover_high) else $error("recovery or turn wrong");

  property p_turn_release;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (state == sirq_pkg::SIRQ_FRAMES && phase == `SIRQ_PH_TURN) |-> !wire_oe_o;
  endproperty
  a_turn_release: assert property (p_turn_release) else $error("drive in turn-around");

  property p_frame_len;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (state == sirq_pkg::SIRQ_FRAMES && phase == `SIRQ_PH_SAMPLE)
      |=> phase == `SIRQ_PH_RECOVER ##1 phase == `SIRQ_PH_TURN;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame not three clocks");

  property p_reset_cont;
    @(posedge sys_clk_i) $rose(reset_n_i) |-> !quiet;
  endproperty
  a_reset_cont: assert property (p_reset_cont) else $error("not continuous after reset");

  property p_mode_stop;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      $changed(quiet) |-> $past(state) == sirq_pkg::SIRQ_STOP;
  endproperty
  a_mode_stop: assert property (p_mode_stop) else $error("mode changed outside stop");

  property p_no_high_drive;
    @(posedge sys_clk_i) disable iff (!reset_n_i)
      (wire_oe_o && wire_o) |-> $past(wire_oe_o) && !$past(wire_o);
  endproperty
  a_no_high_drive: assert property (p_no_high_drive) else $error("high drive not after low");
endmodule : sirq_slave

/* hw/sirq_sync.sv */
// Three-stage synchroniser with agreement filter on the last two stages.
// Assumes an asynchronous level input and one clock domain.
`timescale 1ns/1ps
module sirq_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level_o <= INIT;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          level_o[i] <= s3[i];
        end
      end
    end
  end
endmodule : sirq_sync
